/* bpc_pkg.sv */
/*
  bpc_pkg: constants and carrier types for the buck power-control register.
  assumes: one 40 MHz clock domain; register access arrives as a decoded
  internal write/read strobe from the device's serial configuration logic.
*/
package bpc_pkg;
  localparam logic [7:0] BPC_ADDR_POWER_CHANNEL_CONTROL = 8'h0a;
  localparam logic [7:0] BPC_RESET_VALUE = 8'h7f;
  localparam int BPC_BIT_CH1 = 0;
  localparam int BPC_BIT_CH2 = 1;
  localparam int BPC_BIT_CH3 = 2;
  localparam int BPC_BIT_SKIP = 3;
  localparam int BPC_BIT_LOCKOUT = 6;
  localparam int BPC_NUM_CH = 3;
  // bits that carry function; the rest are stored but ignored
  localparam logic [7:0] BPC_FUNC_MASK = 8'h4f;

  // register access request from the configuration bus logic
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bpc_req_t;

  // control outputs to the power stage
  typedef struct packed {
    logic [2:0] ch_start;
    logic light_load_skip_enable;
    logic input_lockout_threshold_select;
  } bpc_ctrl_t;
endpackage : bpc_pkg

/* bpc_power_ctrl.sv */
/*
  bpc_power_ctrl: power-channel-control register and enable-edge start logic.
  assumes: req and enable_pin are synchronous to clk; reads return the stored
  byte one cycle after rd_en; enable_pin is already debounced.
*/
`timescale 1ns/1ps
module bpc_power_ctrl
  import bpc_pkg::*;
#(
  // register width; the bus and readback path are built for one byte
  parameter int DATA_W = 8,
  // number of buck channels served by the select bits
  parameter int NUM_CH = BPC_NUM_CH
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire bpc_req_t req,
  input wire logic enable_pin,
  output bpc_ctrl_t ctrl,
  output logic [7:0] rdata,
  output logic rvalid
);

  logic [7:0] reg_ff, nxt_reg;
  logic en_ff, nxt_en;
  logic [2:0] start_ff, nxt_start;
  logic skip_ff, nxt_skip;
  logic lock_ff, nxt_lock;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic hit;

  // timing seen from the bus side:
  //   a write taken at edge n is in reg_ff after n, and skip and lockout
  //   follow one edge later, since they are registered again for glitch-free pins.
  //   a read taken at edge n shows rvalid and rdata after n for one cycle;
  //   rdata then holds until the next read.
  // timing seen from the enable pin:
  //   the first sample of enable_pin high after a low sample latches the
  //   select bits into the start mask; a low sample clears the mask.
  //   the mask is frozen while enabled, so a late write cannot start or stop
  //   a converter part way through a power-up.
  // limitation: enable_pin is taken as already clean; a bouncing pin would
  // latch the mask more than once.

  // the ports are fixed at one byte and three channels; refuse anything else
  if (DATA_W != 8) begin : g_bad_width
    $error("DATA_W must be 8 for this register");
  end
  if (NUM_CH != BPC_NUM_CH) begin : g_bad_channels
    $error("NUM_CH must match the three select bits");
  end

  // pick the three channel select bits out of the stored byte
  function automatic logic [2:0] chan_sel(input logic [7:0] r);
    return r[BPC_BIT_CH3:BPC_BIT_CH1];
  endfunction : chan_sel

  // keep only the bits that act on the power stage
  function automatic logic [7:0] func_bits(input logic [7:0] r);
    return r & BPC_FUNC_MASK;
  endfunction : func_bits

  // address decode shared by the write and read paths
  function automatic logic addr_hit(input logic [7:0] a);
    return a == BPC_ADDR_POWER_CHANNEL_CONTROL;
  endfunction : addr_hit

  // next-state: write decode, edge detect, control derivation
  always_comb begin
    hit = addr_hit(req.addr);
    nxt_reg = reg_ff;
    if (req.wr_en && hit) begin
      nxt_reg = req.wdata; // unused bits stored for readback only
    end
    nxt_en = enable_pin;
    // selection is sampled at the edge; later writes do not start channels mid-run
    nxt_start = start_ff;
    if (!enable_pin) begin
      nxt_start = 3'h0;
    end else if (!en_ff) begin
      nxt_start = chan_sel(reg_ff);
    end
    nxt_skip = reg_ff[BPC_BIT_SKIP];
    nxt_lock = reg_ff[BPC_BIT_LOCKOUT];
    nxt_rvalid = req.rd_en;
    nxt_rdata = rdata_ff;
    if (req.rd_en) begin
      nxt_rdata = hit ? reg_ff : 8'h00; // other addresses belong elsewhere
    end
  end

  // registers; reset loads the factory value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_ff <= BPC_RESET_VALUE;
      en_ff <= 1'b0;
      start_ff <= 3'h0;
      skip_ff <= BPC_RESET_VALUE[BPC_BIT_SKIP];
      lock_ff <= BPC_RESET_VALUE[BPC_BIT_LOCKOUT];
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      reg_ff <= nxt_reg;
      en_ff <= nxt_en;
      start_ff <= nxt_start;
      skip_ff <= nxt_skip;
      lock_ff <= nxt_lock;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // one driver for the whole carrier; every field comes straight from a flip-flop
  assign ctrl = '{ch_start: start_ff, light_load_skip_enable: skip_ff, input_lockout_threshold_select: lock_ff};
  assign rdata = rdata_ff;
  assign rvalid = rvalid_ff;

  // checks
  a_start_on_edge: assert property (@(posedge clk) disable iff (!rst_b)
    (enable_pin && !en_ff) |=> (start_ff == $past(chan_sel(reg_ff))))
    else $error("start mask not taken from select bits at enable edge");
  a_start_off_low: assert property (@(posedge clk) disable iff (!rst_b)
    !enable_pin |=> (start_ff == 3'h0))
    else $error("channels started while enable low");
  a_start_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (enable_pin && en_ff) |=> $stable(start_ff))
    else $error("start mask changed without enable edge");
  a_skip_follow: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 (skip_ff == $past(reg_ff[3])))
    else $error("skip enable does not follow bit 3");
  a_lock_follow: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 (lock_ff == $past(reg_ff[6])))
    else $error("lockout select does not follow bit 6");
  a_reg_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !(req.wr_en && hit) |=> $stable(reg_ff))
    else $error("register changed without write");
  a_reg_write: assert property (@(posedge clk) disable iff (!rst_b)
    (req.wr_en && hit) |=> (reg_ff == $past(req.wdata)))
    else $error("write not stored");
  a_dont_care: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(func_bits(reg_ff)) == func_bits(reg_ff) && en_ff && enable_pin) |=> $stable(ctrl))
    else $error("unused bits affected control");
  a_read_data: assert property (@(posedge clk) disable iff (!rst_b)
    (req.rd_en && hit) |=> (rvalid && rdata == $past(reg_ff)))
    else $error("read data wrong");
  // a mask may only stand while the pin was seen high
  a_start_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !en_ff |-> (start_ff == 3'h0))
    else $error("start mask set while enable was low");
  // reads of other addresses still answer, with zero
  a_read_other: assert property (@(posedge clk) disable iff (!rst_b)
    (req.rd_en && !hit) |=> (rvalid && rdata == 8'h00))
    else $error("unmapped read did not return zero");
  // rvalid is a single pulse per read strobe
  a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    !req.rd_en |=> !rvalid)
    else $error("rvalid without a read");
  // rdata holds between reads so a slow consumer still sees it
  a_rdata_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !req.rd_en |=> $stable(rdata))
    else $error("read data moved without a read");
  // writes aimed at other registers leave this one alone
  a_other_write: assert property (@(posedge clk) disable iff (!rst_b)
    (req.wr_en && !hit) |=> $stable(reg_ff))
    else $error("foreign write changed the register");

  c_enable_edge: cover property (@(posedge clk) disable iff (!rst_b) enable_pin && !en_ff && reg_ff[2:0] != 3'h7);
  c_skip_off: cover property (@(posedge clk) disable iff (!rst_b) !skip_ff);
  c_low_lockout: cover property (@(posedge clk) disable iff (!rst_b) !lock_ff);
  c_write_read: cover property (@(posedge clk) disable iff (!rst_b) (req.wr_en && hit) ##1 (req.rd_en && hit));
  c_read_other: cover property (@(posedge clk) disable iff (!rst_b) req.rd_en && !hit);

endmodule : bpc_power_ctrl

/* bpc_host.sv */
/* host model: issues register writes and reads.
   assumes: shares clk with the design; caller sits at a rising edge. */
`timescale 1ns/1ps
module bpc_host
  import bpc_pkg::*;
(
  input wire logic clk,
  output bpc_req_t req
);
  initial req = '0;
  // one-cycle strobe, then an idle edge so back-to-back calls never write req twice at once
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    req <= '{w, !w, a, d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : acc
endmodule : bpc_host

/* tb_top.sv */
/* bench for the power-control register.
   assumes: host model in bpc_host; assertions live in the design. */
`timescale 1ns/1ps
module tb_top;
  import bpc_pkg::*;
  logic clk = 0;
  logic rst_b = 0;
  logic en = 0;
  bpc_req_t req;
  bpc_ctrl_t ctrl;
  logic [7:0] rdata, d;
  logic rvalid;
  logic [31:0] seed = 32'hbb79e16a;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int checks_done = 0;
  bpc_host host_u (.clk(clk), .req(req));
  bpc_power_ctrl dut_u (.clk(clk), .rst_b(rst_b), .req(req), .enable_pin(en),
    .ctrl(ctrl), .rdata(rdata), .rvalid(rvalid));
  initial forever #12.5 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // read results come back in request order
  always @(posedge clk) if (rvalid === 1'b1) chk(rdata, exp_q.pop_front());
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({3'h0, ctrl}, 8'h03);
    exp_q.push_back(8'h7f);
    host_u.acc(1'b0, 8'h0a, 8'h00);
    exp_q.push_back(8'h00);
    host_u.acc(1'b0, 8'h0b, 8'h00);
    $display("test reset done");
    // random bytes cover the ignored bits 4, 5 and 7 too
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      d = seed[7:0];
      host_u.acc(1'b1, 8'h0a, d);
      exp_q.push_back(d);
      host_u.acc(1'b0, 8'h0a, 8'h00);
      en <= 1'b1;
      host_u.acc(1'b1, 8'h0b, ~d);
      repeat (2) @(posedge clk);
      chk({3'h0, ctrl}, {3'h0, d[2:0], d[3], d[6]});
      // a rewrite while enabled moves skip and lockout but not the start mask
      host_u.acc(1'b1, 8'h0a, ~d);
      @(posedge clk);
      chk({3'h0, ctrl}, {3'h0, d[2:0], ~d[3], ~d[6]});
      en <= 1'b0;
      @(posedge clk);
    end
    $display("test random done");
    // reset in mid-run must bring the factory value back
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({3'h0, ctrl}, 8'h03);
    exp_q.push_back(8'h7f);
    host_u.acc(1'b0, 8'h0a, 8'h00);
    @(posedge clk);
    chk(8'(exp_q.size()), 8'h00);
    $display("test midreset done");
    end_of_test();
  end
  // the run needs about 510 cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule : tb_top
